/* File: include/intexp_pkg.sv */
package intexp_pkg;
  // ****************************************
  // Sizes and register indices
  // ****************************************
  localparam int NUM_SRC = 14;
  localparam int NUM_LINES = 6;
  localparam int ADDR_W = 17;
  // Word index; byte address is four times the index
  localparam logic [14:0] IDX_SRC_FLAG = 15'h7000;
  localparam logic [14:0] IDX_SRC_ENABLE = 15'h7001;
  localparam logic [14:0] IDX_LINE_MASK = 15'h7002;
  localparam logic [14:0] IDX_PENDING = 15'h7003;
  localparam logic [14:0] IDX_STATUS_ZERO = 15'h7004;
  localparam logic [14:0] IDX_EV_VECTOR_A = 15'h7005;
  localparam logic [14:0] IDX_LOW_VECTOR = 15'h7006;
  localparam logic [14:0] IDX_IRQ_STATUS = 15'h7007;
  localparam logic [14:0] IDX_IRQ_MASK = 15'h7008;
  localparam logic [14:0] IDX_SYS_VECTOR = 15'h701E;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int GMASK_BIT = 9;
  localparam int IRQ_ACK_BIT = 0;
  localparam int IRQ_PHANTOM_BIT = 1;
  localparam logic GMASK_RST = 1'b1;
  localparam logic [5:0] LINE_MASK_RST = 6'h00;
  localparam logic [13:0] ENABLE_RST = 14'h0000;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  // ****************************************
  // Vector offsets, low index ranks highest
  // ****************************************
  localparam logic [15:0] PHANTOM_CODE = 16'h0000;
  localparam logic [127:0] LINE1_CODES = {16'h0020, 16'h0010, 16'h0007, 16'h0006,
    16'h0005, 16'h001F, 16'h0011, 16'h0001};
  localparam logic [47:0] LINE2_CODES = {16'h0023, 16'h0022, 16'h0021};
  localparam logic [47:0] LINE5_CODES = {16'h0007, 16'h0006, 16'h0005};
  // Core vector locations for lines one to six, nonmaskable and trap
  localparam logic [95:0] LINE_VECTORS = {16'h000C, 16'h000A, 16'h0008,
    16'h0006, 16'h0004, 16'h0002};
  localparam logic [15:0] NMI_VECTOR = 16'h0024;
  localparam logic [15:0] TRAP_VECTOR = 16'h0022;
endpackage : intexp_pkg

/* File: design/prio_pick.sv */
`timescale 1ns/100ps
`default_nettype none
module prio_pick #(
  parameter int N = 3,
  parameter logic [N*16-1:0] CODES = '0
) (
  input wire logic [N-1:0] active_i,
  output logic any_o,
  output logic [15:0] code_o
);
  // ****************************************
  // Fixed priority pick, index 0 highest
  // ****************************************
  // Downward scan so the lowest active index is written last
  always_comb
  begin
    any_o = |active_i;
    code_o = intexp_pkg::PHANTOM_CODE;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (active_i[i])
      begin
        code_o = CODES[i*16 +: 16];
      end
    end
  end
endmodule : prio_pick
`default_nettype wire

/* File: design/int_expander.sv */
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module int_expander (
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [16:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Pin sources: ext one, two, three, drive protect
  input wire logic [3:0] pin_request_i,
  input wire logic nmi_pin_n_i,
  // On-chip sources, same clock
  input wire logic [9:0] onchip_request_i,
  // Requests of lines three, four and six from outside this block
  input wire logic [2:0] ext_line_req_i,
  input wire logic trap_i,
  output logic branch_o,
  output logic [15:0] vector_o,
  output logic [5:0] ack_lines_o,
  output logic global_mask_o,
  output logic irq_o
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_prev;
    logic nmi_pend;
    logic trap_pend;
    logic [13:0] flag;
    logic [13:0] enable;
    logic [5:0] line_mask;
    logic [5:0] pending;
    logic gmask;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic resp;
    logic [31:0] rdata;
    logic branch;
    logic [15:0] vector;
    logic [5:0] ack_lines;
  } state_s;

  localparam state_s RST_STATE = '{sync1: 4'h0, sync2: 4'h0, nmi_s1: 1'b0, nmi_s2: 1'b0,
    nmi_prev: 1'b0, nmi_pend: 1'b0, trap_pend: 1'b0, flag: 14'h0000,
    enable: intexp_pkg::ENABLE_RST, line_mask: intexp_pkg::LINE_MASK_RST,
    pending: 6'h00, gmask: intexp_pkg::GMASK_RST, irq_stat: 2'h0,
    irq_mask: intexp_pkg::IRQ_MASK_RST, resp: 1'b0, rdata: 32'h00000000,
    branch: 1'b0, vector: 16'h0000, ack_lines: 6'h00};

  state_s r_reg;
  state_s r_next;
  logic [13:0] src_raw;
  logic [13:0] active;
  logic any1;
  logic any2;
  logic any5;
  logic [15:0] code1;
  logic [15:0] code2;
  logic [15:0] code5;
  logic [5:0] line_req;
  logic [5:0] cand;
  logic [5:0] pick;
  logic [14:0] idx;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic wr;
  logic [15:0] rval;

  // ****************************************
  // Source gathering and arbitration
  // ****************************************
  // Pins are read only after the second synchroniser stage
  assign src_raw = {onchip_request_i[9:4], r_reg.sync2[3], onchip_request_i[3:0], r_reg.sync2[2:0]};
  assign active = r_reg.flag & r_reg.enable;

  // System group on line one
  prio_pick #(.N(8), .CODES(intexp_pkg::LINE1_CODES)) u_line1 (
    .active_i(active[7:0]),
    .any_o(any1),
    .code_o(code1)
  );

  // Event group A on line two
  prio_pick #(.N(3), .CODES(intexp_pkg::LINE2_CODES)) u_line2 (
    .active_i(active[10:8]),
    .any_o(any2),
    .code_o(code2)
  );

  // Low-priority system group on line five
  prio_pick #(.N(3), .CODES(intexp_pkg::LINE5_CODES)) u_line5 (
    .active_i(active[13:11]),
    .any_o(any5),
    .code_o(code5)
  );

  // Lines one, five from system groups; two local, three, four, six come in
  assign line_req = {ext_line_req_i[2], any5, ext_line_req_i[1], ext_line_req_i[0], any2, any1};

  // Acknowledge candidates: pending, unmasked, global mask clear
  assign cand = r_reg.gmask ? 6'h00 : (r_reg.pending & r_reg.line_mask);
  assign pick = cand & (~cand + 6'h01);

  // ****************************************
  // Bus decode
  // ****************************************
  // One wait cycle: request seen, answered on the next edge
  assign idx = address[16:2];
  assign wr = write & r_reg.resp;
  assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wval = writedata[15:0] & wmask;
  assign waitrequest = (read | write) & ~r_reg.resp;

  // Read mux; vector reads reflect the arbitration at read time
  always_comb
  begin
    rval = 16'h0000;
    if (idx == intexp_pkg::IDX_SRC_FLAG)
    begin
      rval = {2'h0, r_reg.flag};
    end
    else if (idx == intexp_pkg::IDX_SRC_ENABLE)
    begin
      rval = {2'h0, r_reg.enable};
    end
    else if (idx == intexp_pkg::IDX_LINE_MASK)
    begin
      rval = {10'h000, r_reg.line_mask};
    end
    else if (idx == intexp_pkg::IDX_PENDING)
    begin
      rval = {10'h000, r_reg.pending};
    end
    else if (idx == intexp_pkg::IDX_STATUS_ZERO)
    begin
      rval[intexp_pkg::GMASK_BIT] = r_reg.gmask;
    end
    else if (idx == intexp_pkg::IDX_SYS_VECTOR)
    begin
      rval = code1;
    end
    else if (idx == intexp_pkg::IDX_EV_VECTOR_A)
    begin
      rval = code2;
    end
    else if (idx == intexp_pkg::IDX_LOW_VECTOR)
    begin
      rval = code5;
    end
    else if (idx == intexp_pkg::IDX_IRQ_STATUS)
    begin
      rval = {14'h0000, r_reg.irq_stat};
    end
    else if (idx == intexp_pkg::IDX_IRQ_MASK)
    begin
      rval = {14'h0000, r_reg.irq_mask};
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    r_next = r_reg;
    r_next.sync1 = pin_request_i;
    r_next.sync2 = r_reg.sync1;
    r_next.nmi_s1 = ~nmi_pin_n_i;
    r_next.nmi_s2 = r_reg.nmi_s1;
    r_next.nmi_prev = r_reg.nmi_s2;
    r_next.resp = (read | write) & ~r_reg.resp;
    r_next.branch = 1'b0;
    r_next.ack_lines = 6'h00;
    // Capture read data in the wait cycle, present it when answered
    if (read & ~r_reg.resp)
    begin
      r_next.rdata = {16'h0000, rval};
    end
    // Register writes; clears first so hardware sets below win
    if (wr)
    begin
      if (idx == intexp_pkg::IDX_SRC_FLAG)
      begin
        r_next.flag = r_reg.flag & ~wval[13:0];
      end
      else if (idx == intexp_pkg::IDX_SRC_ENABLE)
      begin
        r_next.enable = (r_reg.enable & ~wmask[13:0]) | wval[13:0];
      end
      else if (idx == intexp_pkg::IDX_LINE_MASK)
      begin
        r_next.line_mask = (r_reg.line_mask & ~wmask[5:0]) | wval[5:0];
      end
      else if (idx == intexp_pkg::IDX_PENDING)
      begin
        r_next.pending = r_reg.pending & ~wval[5:0];
      end
      else if (idx == intexp_pkg::IDX_STATUS_ZERO)
      begin
        if (wmask[intexp_pkg::GMASK_BIT])
        begin
          r_next.gmask = wval[intexp_pkg::GMASK_BIT];
        end
      end
      else if (idx == intexp_pkg::IDX_IRQ_STATUS)
      begin
        r_next.irq_stat = r_reg.irq_stat & ~wval[1:0];
      end
      else if (idx == intexp_pkg::IDX_IRQ_MASK)
      begin
        r_next.irq_mask = (r_reg.irq_mask & ~wmask[1:0]) | wval[1:0];
      end
    end
    // Phantom: system vector register read while its line one group is idle
    if (read & ~r_reg.resp & (idx == intexp_pkg::IDX_SYS_VECTOR) & ~any1)
    begin
      r_next.irq_stat[intexp_pkg::IRQ_PHANTOM_BIT] = 1'b1;
    end
    // Falling edge of the nonmaskable pin, and trap requests
    if (r_reg.nmi_s2 & ~r_reg.nmi_prev)
    begin
      r_next.nmi_pend = 1'b1;
    end
    if (trap_i)
    begin
      r_next.trap_pend = 1'b1;
    end
    // Acknowledge: nonmaskable, then lines by rank, trap last
    if (r_reg.nmi_pend)
    begin
      r_next.nmi_pend = 1'b0;
      r_next.branch = 1'b1;
      r_next.vector = intexp_pkg::NMI_VECTOR;
      r_next.gmask = 1'b1;
    end
    else if (|pick)
    begin
      r_next.branch = 1'b1;
      r_next.ack_lines = pick;
      r_next.pending = r_next.pending & ~pick;
      r_next.gmask = 1'b1;
      r_next.irq_stat[intexp_pkg::IRQ_ACK_BIT] = 1'b1;
      for (int i = 0; i < intexp_pkg::NUM_LINES; i++)
      begin
        if (pick[i])
        begin
          r_next.vector = intexp_pkg::LINE_VECTORS[i*16 +: 16];
        end
      end
    end
    else if (r_reg.trap_pend)
    begin
      // Trap leaves the global mask alone
      r_next.trap_pend = trap_i;
      r_next.branch = 1'b1;
      r_next.vector = intexp_pkg::TRAP_VECTOR;
    end
    // Hardware sets win over clears in the same cycle
    r_next.flag = r_next.flag | src_raw;
    r_next.pending = r_next.pending | line_req;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r_reg <= RST_STATE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from state
  assign readdata = r_reg.rdata;
  assign branch_o = r_reg.branch;
  assign vector_o = r_reg.vector;
  assign ack_lines_o = r_reg.ack_lines;
  assign global_mask_o = r_reg.gmask;
  assign irq_o = |(r_reg.irq_stat & r_reg.irq_mask);

  // ****************************************
  // Checks
  // ****************************************
  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    |src_raw |=> ((r_reg.flag & $past(src_raw)) == $past(src_raw)))
    else $error("Source request did not set its flag");

  pending_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    |line_req |=> ((r_reg.pending & $past(line_req)) == $past(line_req)))
    else $error("Forwarded request not pending");

  mask_holds_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|ack_lines_o) |-> !$past(r_reg.gmask))
    else $error("Maskable line taken while globally masked");

  ack_sets_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (branch_o && vector_o != intexp_pkg::TRAP_VECTOR) |-> r_reg.gmask)
    else $error("Acknowledge left global mask clear");

  line_mask_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|ack_lines_o) |-> ((ack_lines_o & $past(r_reg.line_mask)) == ack_lines_o))
    else $error("Masked line acknowledged");

  priority_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|ack_lines_o) |-> (($past(cand) & (ack_lines_o - 6'h01)) == 6'h00))
    else $error("Lower ranked line acknowledged first");

  line_one_vector_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_lines_o[0] |-> (branch_o && vector_o == 16'h0002))
    else $error("Wrong vector for line one");

  phantom_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (read && !r_reg.resp && idx == intexp_pkg::IDX_SYS_VECTOR && !any1)
    |=> (readdata == 32'h00000000) ##0 !waitrequest)
    else $error("Phantom offset not returned");

  vector_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (read && !r_reg.resp && idx == intexp_pkg::IDX_SYS_VECTOR && active[0])
    |=> (readdata[15:0] == 16'h0001))
    else $error("Top source offset not returned");

  nmi_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r_reg.nmi_pend |=> (branch_o && vector_o == intexp_pkg::NMI_VECTOR && ack_lines_o == 6'h00))
    else $error("Nonmaskable not taken first");
endmodule : int_expander
`default_nettype wire

/* File: verif/req_source.sv */
`timescale 1ns/100ps
`default_nettype none
module req_source (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [13:0] set_i,
  input wire logic [13:0] clr_i,
  output logic [9:0] onchip_o,
  output logic [3:0] pin_o
);
  // ****************************************
  // Request levels
  // ****************************************
  logic [13:0] lvl_reg;
  // Sources keep asking until told to drop, so flags re-set as in hardware
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lvl_reg <= 14'h0000;
    else
      lvl_reg <= (lvl_reg | set_i) & ~clr_i;
  end
  // Low ten feed on-chip requests, top four the pins
  assign onchip_o = lvl_reg[9:0];
  assign pin_o = lvl_reg[13:10];
endmodule : req_source
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_i, rst_i, read, write, waitrequest, trap, branch, gmask, irq;
  logic [16:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [13:0] set_v, clr_v;
  logic [9:0] onchip;
  logic [3:0] pins;
  logic [15:0] vec;
  logic [5:0] acks;
  logic nmi_n;
  logic [2:0] ext_req;
  int n_errors, n_tests;
  // ****************************************
  // Clock, instances
  // ****************************************
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  req_source src_u (.clk_i(clk_i), .rst_i(rst_i), .set_i(set_v), .clr_i(clr_v), .onchip_o(onchip), .pin_o(pins));
  int_expander dut_u (.clk_i(clk_i), .rst_i(rst_i), .address(address), .read(read), .write(write),
    .byteenable(4'hF), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .pin_request_i(pins), .nmi_pin_n_i(nmi_n), .onchip_request_i(onchip), .ext_line_req_i(ext_req),
    .trap_i(trap), .branch_o(branch), .vector_o(vec), .ack_lines_o(acks), .global_mask_o(gmask), .irq_o(irq));
  // ****************************************
  // Shared tasks
  // ****************************************
  task conclude;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // One Avalon access; request held up to the edge that samples waitrequest low
  task bus(input logic wr, input logic [14:0] idx, input logic [15:0] wd);
    int k;
    @(posedge clk_i);
    read <= !wr;
    write <= wr;
    address <= {idx, 2'b00};
    writedata <= {16'h0000, wd};
    k = 0;
    @(posedge clk_i);
    while (waitrequest !== 1'b0 && k < 20)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k == 20)
    begin
      n_errors++;
      conclude();
    end
    // Data taken at the answering edge, before the slave moves on
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task rdc(input logic [14:0] idx, input logic [15:0] exp, input string what);
    bus(1'b0, idx, 16'h0000);
    chk(rd, {16'h0000, exp}, what);
  endtask : rdc
  task src(input logic [13:0] s, input logic [13:0] c);
    @(posedge clk_i);
    set_v <= s;
    clr_v <= c;
    @(posedge clk_i);
    set_v <= 14'h0000;
    clr_v <= 14'h0000;
  endtask : src
  // Bounded wait for the forced branch pulse
  task wait_br(input logic [15:0] ev, input logic [5:0] ea, input logic em);
    int k;
    k = 0;
    while (branch !== 1'b1 && k < 20)
    begin
      @(negedge clk_i);
      k++;
    end
    if (k == 20)
    begin
      n_errors++;
      conclude();
    end
    chk(vec, ev, "vector");
    chk(acks, ea, "ack lines");
    chk(gmask, em, "mask after branch");
  endtask : wait_br
  task no_br(input int n);
    repeat (n)
    begin
      @(negedge clk_i);
      chk(branch, 1'b0, "no branch");
    end
  endtask : no_br
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    chk(gmask, 1'b1, "mask at reset");
    rdc(intexp_pkg::IDX_SRC_ENABLE, 16'h0000, "enables");
    rdc(intexp_pkg::IDX_LINE_MASK, 16'h0000, "line mask");
    rdc(intexp_pkg::IDX_STATUS_ZERO, 16'h0200, "status zero");
    rdc(15'h7010, 16'h0000, "unmapped");
    rdc(intexp_pkg::IDX_SYS_VECTOR, intexp_pkg::PHANTOM_CODE, "phantom");
    rdc(intexp_pkg::IDX_IRQ_STATUS, 16'h0002, "phantom event");
    bus(1'b1, intexp_pkg::IDX_IRQ_STATUS, 16'h0002);
    rdc(intexp_pkg::IDX_IRQ_STATUS, 16'h0000, "event cleared");
    $display("t_reset done");
  endtask : t_reset
  // One source alone shows its code, then the group falls back to idle
  task one_src(input int sb, input int fb, input logic [14:0] vr, input logic [15:0] exp);
    src(14'(1) << sb, 14'h0000);
    repeat (4) @(posedge clk_i);
    rdc(vr, exp, "source code");
    src(14'h0000, 14'(1) << sb);
    bus(1'b1, intexp_pkg::IDX_SRC_FLAG, 16'(1) << fb);
    rdc(vr, 16'h0000, "group idle");
  endtask : one_src
  task t_codes;
    bus(1'b1, intexp_pkg::IDX_SRC_ENABLE, 16'h3FFF);
    one_src(10, 0, intexp_pkg::IDX_SYS_VECTOR, 16'h0001);
    one_src(11, 1, intexp_pkg::IDX_SYS_VECTOR, 16'h0011);
    one_src(12, 2, intexp_pkg::IDX_SYS_VECTOR, 16'h001F);
    one_src(0, 3, intexp_pkg::IDX_SYS_VECTOR, 16'h0005);
    one_src(1, 4, intexp_pkg::IDX_SYS_VECTOR, 16'h0006);
    one_src(2, 5, intexp_pkg::IDX_SYS_VECTOR, 16'h0007);
    one_src(3, 6, intexp_pkg::IDX_SYS_VECTOR, 16'h0010);
    one_src(13, 7, intexp_pkg::IDX_SYS_VECTOR, 16'h0020);
    one_src(4, 8, intexp_pkg::IDX_EV_VECTOR_A, 16'h0021);
    one_src(5, 9, intexp_pkg::IDX_EV_VECTOR_A, 16'h0022);
    one_src(6, 10, intexp_pkg::IDX_EV_VECTOR_A, 16'h0023);
    // Pending bits stay after the flags go, so sweep them for the next test
    bus(1'b1, intexp_pkg::IDX_PENDING, 16'h003F);
    rdc(intexp_pkg::IDX_PENDING, 16'h0000, "pending swept");
    $display("t_codes done");
  endtask : t_codes
  // Competing sources, enable gating, flags and pending
  task t_arb;
    src(14'h0409, 14'h0000);
    repeat (4) @(posedge clk_i);
    rdc(intexp_pkg::IDX_SRC_FLAG, 16'h0049, "flags");
    rdc(intexp_pkg::IDX_PENDING, 16'h0001, "pending");
    rdc(intexp_pkg::IDX_SYS_VECTOR, 16'h0001, "top wins");
    src(14'h0000, 14'h0400);
    bus(1'b1, intexp_pkg::IDX_SRC_FLAG, 16'h0001);
    bus(1'b1, intexp_pkg::IDX_SRC_ENABLE, 16'h3FF7);
    rdc(intexp_pkg::IDX_SYS_VECTOR, 16'h0010, "disabled skipped");
    bus(1'b1, intexp_pkg::IDX_SRC_ENABLE, 16'h3FFF);
    rdc(intexp_pkg::IDX_SYS_VECTOR, 16'h0005, "re-enabled");
    // Clearing a flag whose source still asks must not stick
    bus(1'b1, intexp_pkg::IDX_SRC_FLAG, 16'h0040);
    rdc(intexp_pkg::IDX_SRC_FLAG, 16'h0048, "set wins");
    src(14'h0000, 14'h0401);
    bus(1'b1, intexp_pkg::IDX_SRC_FLAG, 16'h0008);
    $display("t_arb done");
  endtask : t_arb
  // Masks, line order, irq and trap
  task t_ack;
    src(14'h0010, 14'h0000);
    bus(1'b1, intexp_pkg::IDX_STATUS_ZERO, 16'h0000);
    no_br(8);
    bus(1'b1, intexp_pkg::IDX_LINE_MASK, 16'h0003);
    wait_br(16'h0002, 6'h01, 1'b1);
    chk(irq, 1'b0, "irq masked");
    bus(1'b1, intexp_pkg::IDX_IRQ_MASK, 16'h0001);
    @(negedge clk_i);
    chk(irq, 1'b1, "irq raised");
    no_br(8);
    src(14'h0000, 14'h0008);
    bus(1'b1, intexp_pkg::IDX_SRC_FLAG, 16'h0040);
    bus(1'b1, intexp_pkg::IDX_PENDING, 16'h0001);
    bus(1'b1, intexp_pkg::IDX_IRQ_STATUS, 16'h0001);
    @(negedge clk_i);
    chk(irq, 1'b0, "irq cleared");
    bus(1'b1, intexp_pkg::IDX_STATUS_ZERO, 16'h0000);
    wait_br(16'h0004, 6'h02, 1'b1);
    src(14'h0000, 14'h0010);
    bus(1'b1, intexp_pkg::IDX_SRC_FLAG, 16'h0100);
    @(posedge clk_i);
    trap <= 1'b1;
    @(posedge clk_i);
    trap <= 1'b0;
    wait_br(intexp_pkg::TRAP_VECTOR, 6'h00, 1'b1);
    $display("t_ack done");
  endtask : t_ack
  // Outside lines, line five group, nonmaskable pin, trap with mask clear, reset again
  task t_lines;
    src(14'h0180, 14'h0000);
    ext_req <= 3'h7;
    bus(1'b1, intexp_pkg::IDX_PENDING, 16'h003F);
    rdc(intexp_pkg::IDX_PENDING, 16'h003C, "outside lines");
    rdc(intexp_pkg::IDX_LOW_VECTOR, 16'h0005, "line five top");
    bus(1'b1, intexp_pkg::IDX_LINE_MASK, 16'h003C);
    // Nonmaskable is taken even while the global mask holds the lines off
    @(posedge clk_i);
    nmi_n <= 1'b0;
    wait_br(intexp_pkg::NMI_VECTOR, 6'h00, 1'b1);
    @(posedge clk_i);
    nmi_n <= 1'b1;
    bus(1'b1, intexp_pkg::IDX_STATUS_ZERO, 16'h0000);
    wait_br(16'h0006, 6'h04, 1'b1);
    @(posedge clk_i);
    ext_req <= 3'h6;
    bus(1'b1, intexp_pkg::IDX_PENDING, 16'h0004);
    bus(1'b1, intexp_pkg::IDX_STATUS_ZERO, 16'h0000);
    wait_br(16'h0008, 6'h08, 1'b1);
    @(posedge clk_i);
    ext_req <= 3'h4;
    bus(1'b1, intexp_pkg::IDX_PENDING, 16'h0008);
    bus(1'b1, intexp_pkg::IDX_STATUS_ZERO, 16'h0000);
    wait_br(16'h000A, 6'h10, 1'b1);
    src(14'h0000, 14'h0180);
    bus(1'b1, intexp_pkg::IDX_SRC_FLAG, 16'h1800);
    bus(1'b1, intexp_pkg::IDX_PENDING, 16'h0010);
    bus(1'b1, intexp_pkg::IDX_STATUS_ZERO, 16'h0000);
    wait_br(16'h000C, 6'h20, 1'b1);
    @(posedge clk_i);
    ext_req <= 3'h0;
    bus(1'b1, intexp_pkg::IDX_PENDING, 16'h0020);
    bus(1'b1, intexp_pkg::IDX_STATUS_ZERO, 16'h0000);
    @(posedge clk_i);
    trap <= 1'b1;
    @(posedge clk_i);
    trap <= 1'b0;
    wait_br(intexp_pkg::TRAP_VECTOR, 6'h00, 1'b0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(intexp_pkg::IDX_STATUS_ZERO, 16'h0200, "mask after reset");
    rdc(intexp_pkg::IDX_LINE_MASK, 16'h0000, "line mask after reset");
    $display("t_lines done");
  endtask : t_lines
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    n_errors = 0;
    n_tests = 0;
    rst_i = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 17'h00000;
    writedata = 32'h00000000;
    set_v = 14'h0000;
    clr_v = 14'h0000;
    trap = 1'b0;
    nmi_n = 1'b1;
    ext_req = 3'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_codes();
    t_arb();
    t_ack();
    t_lines();
    conclude();
  end
endmodule : tb
`default_nettype wire
